/* hdl/gpd_port.sv */
/*
  Eight-pin general-purpose port: direction, output latch, live level
  readback, per-pin debounce, edge-selected events on interrupt line zero.
  Assumes a plain strobe register port on the same clock as the block;
  pin inputs arrive from outside and are synchronised per pin.
*/
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpd_defines.svh"

module gpd_port
  import gpd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire gpd_bus_req_t bus_req_in,
  output logic [`GPD_DW-1:0] rd_data_out,
  input wire logic [`GPD_PINS-1:0] pin_level_in,
  output gpd_pin_drive_t pin_drive_out,
  output logic interrupt_line_zero_out
);

  // ***********************************
  // address decode
  // ***********************************
  function automatic logic gpd_hit(input logic [`GPD_AW-1:0] addr, input logic [`GPD_AW-1:0] ofs);
    gpd_hit = (addr == ofs);
  endfunction

  logic [`GPD_PINS-1:0] pin_direction;
  logic [`GPD_PINS-1:0] out_latch;
  logic [`GPD_DW-1:0] pin_debounce_settings;
  logic [`GPD_SRC-1:0] line0_pin_edge_select;
  logic [`GPD_SRC-1:0] line0_pin_mask;
  logic [`GPD_SRC-1:0] line0_pin_event_flags;
  logic [`GPD_PINS-1:0] clean_prev;
  logic post_rst;

  wire logic [`GPD_PINS-1:0] pin_sync;
  wire logic [`GPD_PINS-1:0] pin_clean;
  wire logic tick;

  wire logic hit_dir = gpd_hit(bus_req_in.addr, `GPD_OFS_DIR);
  wire logic hit_level = gpd_hit(bus_req_in.addr, `GPD_OFS_LEVEL);
  wire logic hit_debounce = gpd_hit(bus_req_in.addr, `GPD_OFS_DEBOUNCE);
  wire logic hit_edge = gpd_hit(bus_req_in.addr, `GPD_OFS_EDGE);
  wire logic hit_mask = gpd_hit(bus_req_in.addr, `GPD_OFS_MASK);
  wire logic hit_flags = gpd_hit(bus_req_in.addr, `GPD_OFS_FLAGS);
  wire logic hit_any = hit_dir || hit_level || hit_debounce || hit_edge || hit_mask || hit_flags;

  wire logic wr_dir = bus_req_in.wr && hit_dir;
  wire logic wr_level = bus_req_in.wr && hit_level;
  wire logic wr_debounce = bus_req_in.wr && hit_debounce;
  wire logic wr_edge = bus_req_in.wr && hit_edge;
  wire logic wr_mask = bus_req_in.wr && hit_mask;
  wire logic wr_flags = bus_req_in.wr && hit_flags;

  // ***********************************
  // tick divider and pin filters
  // ***********************************
  gpd_tick_gen u_tick (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .tick_out(tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `GPD_PINS; gi++) begin : g_pin
      gpd_pin_filter u_filter (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .pin_in(pin_level_in[gi]),
        .tick_in(tick),
        .setting_in(pin_debounce_settings[`GPD_DB_W*gi +: `GPD_DB_W]),
        .sync_out(pin_sync[gi]),
        .clean_out(pin_clean[gi])
      );
    end
  endgenerate

  // ***********************************
  // pin events
  // ***********************************
  wire logic [`GPD_PINS-1:0] rise = pin_clean & ~clean_prev;
  wire logic [`GPD_PINS-1:0] fall = ~pin_clean & clean_prev;
  // bit set selects falling edge, clear selects rising; only input pins raise events
  wire logic [`GPD_PINS-1:0] pin_event =
    ((line0_pin_edge_select[`GPD_PINS-1:0] & fall) |
     (~line0_pin_edge_select[`GPD_PINS-1:0] & rise)) & ~pin_direction;
  wire logic [`GPD_SRC-1:0] src_event = {{(`GPD_SRC-`GPD_PINS){1'b0}}, pin_event};
  wire logic [`GPD_SRC-1:0] flag_clear = wr_flags ? bus_req_in.wdata[`GPD_SRC-1:0] : `GPD_RST_SRC;
  // a new event wins over a clear in the same cycle
  wire logic [`GPD_SRC-1:0] next_flags = (line0_pin_event_flags & ~flag_clear) | src_event;

  // ***********************************
  // read mux
  // ***********************************
  wire logic [`GPD_DW-1:0] rd_mux =
    hit_dir ? {{(`GPD_DW-`GPD_PINS){1'b0}}, pin_direction} :
    hit_level ? {{(`GPD_DW-`GPD_PINS){1'b0}}, pin_sync} :
    hit_debounce ? pin_debounce_settings :
    hit_edge ? {{(`GPD_DW-`GPD_SRC){1'b0}}, line0_pin_edge_select} :
    hit_mask ? {{(`GPD_DW-`GPD_SRC){1'b0}}, line0_pin_mask} :
    hit_flags ? {{(`GPD_DW-`GPD_SRC){1'b0}}, line0_pin_event_flags} : `GPD_RST_DATA;

  // ***********************************
  // registers
  // ***********************************
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_direction <= `GPD_RST_DIR;
      pin_debounce_settings <= `GPD_RST_DEBOUNCE;
      line0_pin_edge_select <= `GPD_RST_SRC;
      line0_pin_mask <= `GPD_RST_SRC;
    end else begin
      if (wr_dir) begin
        pin_direction <= bus_req_in.wdata[`GPD_PINS-1:0];
      end
      if (wr_debounce) begin
        pin_debounce_settings <= bus_req_in.wdata;
      end
      if (wr_edge) begin
        line0_pin_edge_select <= bus_req_in.wdata[`GPD_SRC-1:0];
      end
      if (wr_mask) begin
        line0_pin_mask <= bus_req_in.wdata[`GPD_SRC-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_latch <= `GPD_RST_LEVEL;
    end else if (wr_level) begin
      out_latch <= bus_req_in.wdata[`GPD_PINS-1:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      line0_pin_event_flags <= `GPD_RST_SRC;
      clean_prev <= `GPD_RST_LEVEL;
      interrupt_line_zero_out <= 1'b0;
    end else begin
      line0_pin_event_flags <= next_flags;
      clean_prev <= pin_clean;
      interrupt_line_zero_out <= |(line0_pin_event_flags & line0_pin_mask);
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= `GPD_RST_DATA;
    end else begin
      rd_data_out <= bus_req_in.rd ? rd_mux : `GPD_RST_DATA;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      post_rst <= 1'b0;
    end else begin
      post_rst <= 1'b1;
    end
  end

  // ***********************************
  // pin drive
  // ***********************************
  assign pin_drive_out.level = out_latch;
  assign pin_drive_out.oe = pin_direction;

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_dir_to_enable: assert property (
    wr_dir |=> pin_drive_out.oe == $past(bus_req_in.wdata[`GPD_PINS-1:0]))
    else $error("direction write did not reach the pin enables");

  a_drive_only_output: assert property (
    wr_level && !wr_dir |=> pin_drive_out.level == $past(bus_req_in.wdata[`GPD_PINS-1:0])
                            && pin_drive_out.oe == $past(pin_direction))
    else $error("data write changed drive wrongly");

  a_level_readback: assert property (
    bus_req_in.rd && hit_level |=> rd_data_out == {{(`GPD_DW-`GPD_PINS){1'b0}}, $past(pin_sync)})
    else $error("level read did not return live pin levels");

  sequence s_db_write;
    wr_debounce ##1 (bus_req_in.rd && hit_debounce);
  endsequence

  a_debounce_readback: assert property (
    s_db_write |=> rd_data_out == $past(bus_req_in.wdata, 2))
    else $error("debounce setting did not read back");

  sequence s_rise_on_input;
    (rise[0] && !line0_pin_edge_select[0] && !pin_direction[0]);
  endsequence

  a_edge_event: assert property (
    s_rise_on_input |=> line0_pin_event_flags[0])
    else $error("selected edge did not raise its event flag");

  a_wrong_edge_quiet: assert property (
    fall[0] && !line0_pin_edge_select[0] && !line0_pin_event_flags[0] && !wr_flags
    |=> !line0_pin_event_flags[0])
    else $error("unselected edge raised an event flag");

  a_flag_clear: assert property (
    wr_flags && bus_req_in.wdata[0] && !src_event[0] |=> !line0_pin_event_flags[0])
    else $error("writing one did not clear the event flag");

  a_flag_sticky: assert property (
    line0_pin_event_flags[0] && !(wr_flags && bus_req_in.wdata[0]) |=> line0_pin_event_flags[0])
    else $error("event flag dropped without a clear");

  a_reset_defaults: assert property (
    !post_rst |-> pin_direction == `GPD_RST_DIR && pin_debounce_settings == `GPD_RST_DEBOUNCE
                  && line0_pin_edge_select == `GPD_RST_SRC)
    else $error("port did not start as inputs with zero fields");

  a_irq_follow: assert property (
    |(line0_pin_event_flags & line0_pin_mask) |=> interrupt_line_zero_out)
    else $error("unmasked flag did not raise the interrupt");

  a_read_one_cycle: assert property (
    !bus_req_in.rd |=> rd_data_out == `GPD_RST_DATA)
    else $error("read data stood outside its cycle");

  sequence s_edge_write;
    wr_edge ##1 (bus_req_in.rd && hit_edge);
  endsequence

  a_edge_readback: assert property (
    s_edge_write |=> rd_data_out == {{(`GPD_DW-`GPD_SRC){1'b0}}, $past(bus_req_in.wdata[`GPD_SRC-1:0], 2)})
    else $error("edge select did not read back");

  a_unmapped_read_zero: assert property (
    bus_req_in.rd && !hit_any |=> rd_data_out == `GPD_RST_DATA)
    else $error("unmapped read returned data");

  a_output_no_event: assert property (
    ((line0_pin_event_flags[`GPD_PINS-1:0] & ~$past(line0_pin_event_flags[`GPD_PINS-1:0]))
     & $past(pin_direction)) == '0)
    else $error("output pin raised an event flag");

  a_spare_flags_zero: assert property (
    line0_pin_event_flags[`GPD_SRC-1:`GPD_PINS] == '0)
    else $error("source without a pin raised a flag");

  a_irq_quiet: assert property (
    !(|(line0_pin_event_flags & line0_pin_mask)) |=> !interrupt_line_zero_out)
    else $error("interrupt high with no unmasked flag");

  a_latch_hold: assert property (
    !wr_level |=> pin_drive_out.level == $past(pin_drive_out.level))
    else $error("output latch changed without a write");

  a_dir_hold: assert property (
    !wr_dir |=> pin_drive_out.oe == $past(pin_drive_out.oe))
    else $error("direction changed without a write");

  a_bypass_follow: assert property (
    pin_debounce_settings[`GPD_DB_W-1:0] == '0 && pin_sync[0] != pin_clean[0]
    |=> pin_clean[0] == $past(pin_sync[0]))
    else $error("debounce off did not pass the level");

  a_filter_hold: assert property (
    pin_debounce_settings[`GPD_DB_W-1:0] != '0 && !tick |=> pin_clean[0] == $past(pin_clean[0]))
    else $error("debounced level changed between ticks");

  a_tick_single: assert property (
    tick |=> !tick)
    else $error("tick lasted more than one cycle");

  a_reset_outputs: assert property (
    !post_rst |-> pin_drive_out == '0 && rd_data_out == `GPD_RST_DATA && !interrupt_line_zero_out)
    else $error("outputs not idle after reset");

endmodule
`default_nettype wire

/* hdl/gpd_defines.svh */
/*
  Constants of the general-purpose pin port: widths, register offsets,
  reset values, field positions and timing counts.
  Assumes a 200 MHz system clock and a plain strobe register port.
*/
// What this block does
// - each pin has a direction bit; 0 means input, 1 means output.
// - a written data bit drives its pin only while that pin is an output.
// - reading the data register returns the live pin levels, not written values.
// - two debounce bits per pin, values 0 to 3, pin 0 at bits 1:0.
// - a 12-bit field at bits 11:0 picks the event edge per source.
// - event flags read as pending; writing one clears a flag, zero keeps it.
`ifndef GPD_DEFINES_SVH
`define GPD_DEFINES_SVH

// ***********************************
// widths
// ***********************************
`define GPD_PINS 8
`define GPD_AW 8
`define GPD_DW 16
`define GPD_SRC 12
`define GPD_DB_W 2

// ***********************************
// register offsets
// ***********************************
`define GPD_OFS_DIR 8'h2a
`define GPD_OFS_LEVEL 8'h2b
`define GPD_OFS_DEBOUNCE 8'h2c
`define GPD_OFS_EDGE 8'h30
`define GPD_OFS_MASK 8'h31
`define GPD_OFS_FLAGS 8'h34

// ***********************************
// reset values
// ***********************************
`define GPD_RST_DIR 8'h00
`define GPD_RST_LEVEL 8'h00
`define GPD_RST_DEBOUNCE 16'h0000
`define GPD_RST_SRC 12'h000
`define GPD_RST_DATA 16'h0000

// ***********************************
// timing
// ***********************************
`define GPD_CLK_NS 5
`define GPD_TICK_NS 1000
`define GPD_TICK_CYC (`GPD_TICK_NS / `GPD_CLK_NS)
`define GPD_TICK_CW 8
`define GPD_DB_CW 7
`define GPD_DB_TICKS_1 7'h04
`define GPD_DB_TICKS_2 7'h10
`define GPD_DB_TICKS_3 7'h40

`endif

/* hdl/gpd_pkg.sv */
/*
  Types shared by the pin port modules.
  Assumes gpd_defines.svh is on the include path.
*/
`include "gpd_defines.svh"

package gpd_pkg;

  // ***********************************
  // register port request
  // ***********************************
  typedef struct packed {
    logic [`GPD_AW-1:0] addr;
    logic [`GPD_DW-1:0] wdata;
    logic wr;
    logic rd;
  } gpd_bus_req_t;

  // ***********************************
  // pin drive group
  // ***********************************
  typedef struct packed {
    logic [`GPD_PINS-1:0] level;
    logic [`GPD_PINS-1:0] oe;
  } gpd_pin_drive_t;

  // ***********************************
  // debounce filter states
  // ***********************************
  typedef enum logic [1:0] {
    GPD_DB_STABLE = 2'b00,
    GPD_DB_COUNT = 2'b01
  } gpd_db_state_t;

endpackage

/* hdl/gpd_tick_gen.sv */
/*
  Divider giving a one-cycle tick every debounce time unit.
  Assumes the single system clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpd_defines.svh"

module gpd_tick_gen
  import gpd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  output logic tick_out
);

  localparam logic [`GPD_TICK_CW-1:0] TICK_LAST = `GPD_TICK_CW'(`GPD_TICK_CYC - 1);

  logic [`GPD_TICK_CW-1:0] cnt;
  wire logic at_last = (cnt == TICK_LAST);

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt <= at_last ? '0 : cnt + 1'b1;
      tick_out <= at_last;
    end
  end

endmodule
`default_nettype wire

/* hdl/gpd_pin_filter.sv */
/*
  Two-flop synchroniser and debounce filter for one pin.
  Assumes a tick pulse from gpd_tick_gen on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpd_defines.svh"

module gpd_pin_filter
  import gpd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic pin_in,
  input wire logic tick_in,
  input wire logic [`GPD_DB_W-1:0] setting_in,
  output logic sync_out,
  output logic clean_out
);

  logic meta;
  logic [`GPD_DB_CW-1:0] cnt;
  gpd_db_state_t state;

  // setting 0 passes the level straight through
  wire logic [`GPD_DB_CW-1:0] limit = (setting_in == 2'h1) ? `GPD_DB_TICKS_1 :
                                      (setting_in == 2'h2) ? `GPD_DB_TICKS_2 : `GPD_DB_TICKS_3;
  wire logic differs = (sync_out != clean_out);
  wire logic bypass = (setting_in == 2'h0);
  wire logic [`GPD_DB_CW-1:0] next_cnt = cnt + 1'b1;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= pin_in;
      sync_out <= meta;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= GPD_DB_STABLE;
      cnt <= '0;
      clean_out <= 1'b0;
    end else begin
      unique case (state)
        GPD_DB_STABLE: begin
          cnt <= '0;
          if (differs && setting_in == 2'h0) begin
            clean_out <= sync_out;
          end else if (differs) begin
            state <= GPD_DB_COUNT;
          end
        end
        GPD_DB_COUNT: begin
          if (!differs) begin
            state <= GPD_DB_STABLE;
          end else if (bypass || (tick_in && next_cnt >= limit)) begin
            clean_out <= sync_out;
            state <= GPD_DB_STABLE;
          end else if (tick_in) begin
            cnt <= next_cnt;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* verification/gpd_board.sv */
/*
  board model on the eight pins: resolves each wire level.
  assumes the drive group of gpd_port and a bench-set board level.
*/
`timescale 1ns/1ps
`default_nettype none
module gpd_board
  import gpd_pkg::*;
(
  input wire logic [7:0] board_in,
  input wire gpd_pin_drive_t drive_in,
  output logic [7:0] wire_out
);
  // ****
  // wire level
  // ****
  assign wire_out = (drive_in.oe & drive_in.level) | (~drive_in.oe & board_in);
endmodule
`default_nettype wire

/* verification/testbench.sv */
/*
  self-checking bench of gpd_port.
  assumes gpd_board resolves the pin wires.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpd_defines.svh"
module testbench
  import gpd_pkg::*;
;
  // ****
  // bench
  // ****
  localparam logic [7:0] ofs_dir = `GPD_OFS_DIR;
  localparam logic [7:0] ofs_lv = `GPD_OFS_LEVEL;
  localparam logic [7:0] ofs_db = `GPD_OFS_DEBOUNCE;
  localparam logic [7:0] ofs_ed = `GPD_OFS_EDGE;
  localparam logic [7:0] ofs_mk = `GPD_OFS_MASK;
  localparam logic [7:0] ofs_fl = `GPD_OFS_FLAGS;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  gpd_bus_req_t req = '0;
  logic [15:0] rd_data;
  logic [7:0] board = 8'h00;
  logic [7:0] pins;
  gpd_pin_drive_t drv;
  logic irq;
  logic [31:0] seed = 32'he0eebea2;
  logic [15:0] v;
  logic [7:0] d;
  logic [7:0] e;
  logic [15:0] rbk;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  gpd_port gpd_port_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .bus_req_in(req),
    .rd_data_out(rd_data), .pin_level_in(pins), .pin_drive_out(drv), .interrupt_line_zero_out(irq));
  gpd_board gpd_board_inst (.board_in(board), .drive_in(drv), .wire_out(pins));
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [15:0] exp_wire(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] brd);
    return {8'h00, (dir & lat) | (~dir & brd)};
  endfunction
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic set_board(input logic [7:0] b);
    @(posedge sys_clk_in);
    board <= b;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] dt);
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    req <= '0;
    #1 q = rd_data;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] dt, output logic [15:0] q);
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    req <= '0;
    #1 q = rd_data;
  endtask
  task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic chk_bit(input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    rd(a, q);
    chk_word(exp, q);
  endtask
  task automatic complete_run();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    cycles(2);
    arst_n_in <= 1'b1;
    chk_word(16'h0000, {drv.level, drv.oe});
    chk_reg(ofs_dir, 16'h0000);
    chk_reg(ofs_db, 16'h0000);
    chk_reg(ofs_ed, 16'h0000);
    chk_reg(ofs_mk, 16'h0000);
    chk_reg(ofs_fl, 16'h0000);
    $display("test reset done");
    repeat (6) begin
      v = rnd();
      d = v[7:0];
      e = v[15:8];
      v = rnd();
      wr(ofs_dir, {8'h00, d});
      wr(ofs_lv, v);
      set_board(e);
      cycles(3);
      chk_word({8'h00, d}, {8'h00, drv.oe});
      chk_word(exp_wire(d, v[7:0], e), {8'h00, pins});
      chk_reg(ofs_lv, exp_wire(d, v[7:0], e));
      chk_reg(ofs_dir, {8'h00, d});
    end
    $display("test direction done");
    v = rnd();
    wr_rd(ofs_db, v, rbk);
    chk_word(v, rbk);
    wr_rd(ofs_ed, 16'hffff, rbk);
    chk_word(16'h0fff, rbk);
    wr(8'h40, 16'hffff);
    chk_reg(8'h40, 16'h0000);
    $display("test fields done");
    wr(ofs_db, 16'h0000);
    wr(ofs_dir, 16'h0000);
    wr(ofs_ed, 16'h0000);
    set_board(8'h00);
    cycles(8);
    wr(ofs_fl, 16'h0fff);
    chk_reg(ofs_fl, 16'h0000);
    set_board(8'hff);
    cycles(8);
    chk_bit(1'b0, irq);
    chk_reg(ofs_fl, 16'h00ff);
    wr(ofs_mk, 16'h0080);
    cycles(2);
    chk_bit(1'b1, irq);
    wr(ofs_fl, 16'h0000);
    chk_reg(ofs_fl, 16'h00ff);
    wr(ofs_fl, 16'h0080);
    cycles(2);
    chk_bit(1'b0, irq);
    chk_reg(ofs_fl, 16'h007f);
    $display("test flags done");
    v = rnd();
    e = v[7:0];
    wr(ofs_ed, {8'h00, e});
    set_board(e);
    cycles(8);
    wr(ofs_fl, 16'h0fff);
    for (int i = 0; i < 8; i++) begin
      set_board(board ^ (8'h01 << i));
      cycles(8);
      chk_reg(ofs_fl, 16'h0001 << i);
      wr(ofs_fl, 16'h0001 << i);
      set_board(board ^ (8'h01 << i));
      cycles(8);
      chk_reg(ofs_fl, 16'h0000);
    end
    $display("test edges done");
    wr(ofs_ed, 16'h0000);
    set_board(8'h00);
    cycles(8);
    wr(ofs_db, 16'h0010);
    wr(ofs_fl, 16'h0fff);
    set_board(8'h04);
    cycles(300);
    set_board(8'h00);
    cycles(1000);
    chk_reg(ofs_fl, 16'h0000);
    set_board(8'h04);
    cycles(1200);
    chk_reg(ofs_fl, 16'h0004);
    wr(ofs_db, 16'h0030);
    set_board(8'h00);
    cycles(300);
    wr(ofs_db, 16'h0000);
    wr(ofs_fl, 16'h0004);
    cycles(4);
    set_board(8'h04);
    cycles(8);
    chk_reg(ofs_fl, 16'h0004);
    $display("test debounce done");
    wr(ofs_db, 16'h0000);
    wr(ofs_lv, 16'h0000);
    wr(ofs_dir, 16'h0008);
    cycles(8);
    wr(ofs_fl, 16'h0fff);
    wr(ofs_lv, 16'h0008);
    wr(ofs_lv, 16'h0000);
    cycles(8);
    chk_reg(ofs_fl, 16'h0000);
    $display("test output pin done");
    wr(ofs_db, 16'h5555);
    wr(ofs_ed, 16'h0aaa);
    wr(ofs_lv, 16'h00ff);
    wr(ofs_dir, 16'h00f0);
    @(posedge sys_clk_in);
    arst_n_in <= 1'b0;
    cycles(2);
    arst_n_in <= 1'b1;
    chk_word(16'h0000, {drv.level, drv.oe});
    chk_reg(ofs_dir, 16'h0000);
    chk_reg(ofs_db, 16'h0000);
    chk_reg(ofs_ed, 16'h0000);
    $display("test mid reset done");
    complete_run();
  end
endmodule
`default_nettype wire
